// *** src/bcs_consts.vh ***
`ifndef BCS_CONSTS_VH
`define BCS_CONSTS_VH
// Configuration offsets
`define BCS_CMD_OFFSET 8'h04
`define BCS_STATUS_OFFSET 8'h06
// Status word reset value
`define BCS_STATUS_RESET 16'h0010
// Status bit positions
`define BCS_DETECTED_POISON_BIT 15
`define BCS_SIGNALED_SYSERR_BIT 14
`define BCS_RECEIVED_UNSUP_BIT 13
`define BCS_RECEIVED_CA_BIT 12
`define BCS_SIGNALED_CA_BIT 11
`define BCS_MASTER_POISON_BIT 8
`define BCS_CAP_LIST_BIT 4
`define BCS_SELECT_TIMING_HI_BIT 10
`define BCS_SELECT_TIMING_LO_BIT 9
`define BCS_BACK_TO_BACK_BIT 7
`define BCS_RESERVED_MID_BIT 6
`define BCS_HIGH_SPEED_BIT 5
`define BCS_INT_PENDING_BIT 3
`define BCS_RESERVED_LOW_HI_BIT 2
`define BCS_RESERVED_LOW_LO_BIT 0
// Command word bit positions
`define BCS_POISON_REPORT_EN_BIT 6
`define BCS_SYSERR_REPORT_EN_BIT 8
// Command word reset value
`define BCS_CMD_RESET 16'h0000
`endif

// *** src/bcs_status_word.v ***
`timescale 1ns/10ps
`include "bcs_consts.vh"

module bcs_status_word (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Configuration access
  input wire [7:0] cfg_addr,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [1:0] cfg_be,
  input wire [15:0] cfg_wdata,
  output reg [15:0] cfg_rdata,
  output wire cfg_hit,
  // Transaction events, one-cycle strobes
  input wire ev_poisoned_tlp_rx,
  input wire ev_err_msg_tx,
  input wire ev_cpl_unsupported_rx,
  input wire ev_cpl_abort_rx,
  input wire ev_cpl_abort_tx,
  input wire ev_poisoned_cpl_data_rx,
  input wire ev_write_poisoned,
  // Enables taken from the command word
  input wire [15:0] cmd_word,
  output wire poison_report_enable,
  output wire system_error_report_enable,
  // Status word
  output wire [15:0] status_word
);

  // =====================================================
  // Enables taken from the command word
  // Combinational, so a command change applies to the next event
  assign poison_report_enable = cmd_word[`BCS_POISON_REPORT_EN_BIT];
  assign system_error_report_enable = cmd_word[`BCS_SYSERR_REPORT_EN_BIT];

  // =====================================================
  // Event qualification
  wire set_detected_poison;
  wire set_signaled_syserr;
  wire set_received_unsup;
  wire set_received_ca;
  wire set_signaled_ca;
  wire set_master_poison;
  wire master_poison_event;

  // Poisoned packets count whatever the poison report enable
  assign set_detected_poison = ev_poisoned_tlp_rx;
  // A message sent with reporting off leaves no trace
  assign set_signaled_syserr = ev_err_msg_tx & system_error_report_enable;
  // Completion status returned by the far end
  assign set_received_unsup = ev_cpl_unsupported_rx;
  assign set_received_ca = ev_cpl_abort_rx;
  // Completer abort returned by this bridge
  assign set_signaled_ca = ev_cpl_abort_tx;
  // Either poison source, counted only with reporting on
  assign master_poison_event = ev_poisoned_cpl_data_rx | ev_write_poisoned;
  assign set_master_poison = master_poison_event & poison_report_enable;

  // One set strobe per flag, in flag order
  wire [5:0] ev_set;
  assign ev_set[5] = set_detected_poison;
  assign ev_set[4] = set_signaled_syserr;
  assign ev_set[3] = set_received_unsup;
  assign ev_set[2] = set_received_ca;
  assign ev_set[1] = set_signaled_ca;
  assign ev_set[0] = set_master_poison;

  // =====================================================
  // Write-one-to-clear decode
  wire addr_is_status;
  wire status_wr;
  wire [7:0] clr_low;
  wire [7:0] clr_high;
  wire [15:0] clr_mask;
  wire [5:0] ev_clr;

  // Offset match shared with the read port
  assign addr_is_status = (cfg_addr == `BCS_STATUS_OFFSET);
  // Writes elsewhere in the header leave the flags alone
  assign status_wr = cfg_wr & addr_is_status;
  // Each byte lane clears only when its byte enable is set
  assign clr_low = cfg_wdata[7:0] & {8{cfg_be[0]}};
  assign clr_high = cfg_wdata[15:8] & {8{cfg_be[1]}};
  assign clr_mask = {clr_high, clr_low};
  // Ones written to fixed bit positions have no effect
  assign ev_clr[5] = status_wr & clr_mask[`BCS_DETECTED_POISON_BIT];
  assign ev_clr[4] = status_wr & clr_mask[`BCS_SIGNALED_SYSERR_BIT];
  assign ev_clr[3] = status_wr & clr_mask[`BCS_RECEIVED_UNSUP_BIT];
  assign ev_clr[2] = status_wr & clr_mask[`BCS_RECEIVED_CA_BIT];
  assign ev_clr[1] = status_wr & clr_mask[`BCS_SIGNALED_CA_BIT];
  assign ev_clr[0] = status_wr & clr_mask[`BCS_MASTER_POISON_BIT];

  // =====================================================
  // Sticky flags
  // Set wins over clear so an event in the clearing cycle is never lost
  // Synchronous reset clears every flag
  reg [5:0] flag_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      always @(posedge clk) begin
        if (!rst_n) begin
          flag_ff[gi] <= 1'b0;
        end else if (ev_set[gi]) begin
          flag_ff[gi] <= 1'b1;
        end else if (ev_clr[gi]) begin
          flag_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // =====================================================
  // Flag fan-out
  // Bit 15 down to bit 11, then bit 8
  wire detected_poison_flag;
  wire signaled_system_error_flag;
  wire received_unsupported_flag;
  wire received_completer_abort_flag;
  wire signaled_completer_abort_flag;
  wire master_data_poison_flag;

  assign detected_poison_flag = flag_ff[5];
  assign signaled_system_error_flag = flag_ff[4];
  assign received_unsupported_flag = flag_ff[3];
  assign received_completer_abort_flag = flag_ff[2];
  assign signaled_completer_abort_flag = flag_ff[1];
  assign master_data_poison_flag = flag_ff[0];

  // =====================================================
  // Fixed fields
  wire [1:0] select_timing_field;
  wire back_to_back_capable;
  wire reserved_mid;
  wire high_speed_capable;
  wire capability_list_present;
  wire interrupt_pending_flag;
  wire [2:0] reserved_low;

  // Timing field has no meaning on this link
  assign select_timing_field = 2'b00;
  // No fast back-to-back transfers on this link
  assign back_to_back_capable = 1'b0;
  // Reserved bits
  assign reserved_mid = 1'b0;
  // Conventional bus speed does not apply
  assign high_speed_capable = 1'b0;
  // Further capability structures hang off the header
  assign capability_list_present = 1'b1;
  // The bridge raises no interrupts of its own
  assign interrupt_pending_flag = 1'b0;
  assign reserved_low = 3'b000;

  // =====================================================
  // Status word assembly
  reg [15:0] status_comb;

  always @* begin
    status_comb = 16'h0000;
    // Sticky error flags
    status_comb[`BCS_DETECTED_POISON_BIT] = detected_poison_flag;
    status_comb[`BCS_SIGNALED_SYSERR_BIT] = signaled_system_error_flag;
    status_comb[`BCS_RECEIVED_UNSUP_BIT] = received_unsupported_flag;
    status_comb[`BCS_RECEIVED_CA_BIT] = received_completer_abort_flag;
    status_comb[`BCS_SIGNALED_CA_BIT] = signaled_completer_abort_flag;
    status_comb[`BCS_MASTER_POISON_BIT] = master_data_poison_flag;
    // Read-only fields
    status_comb[`BCS_SELECT_TIMING_HI_BIT:`BCS_SELECT_TIMING_LO_BIT] = select_timing_field;
    status_comb[`BCS_BACK_TO_BACK_BIT] = back_to_back_capable;
    status_comb[`BCS_RESERVED_MID_BIT] = reserved_mid;
    status_comb[`BCS_HIGH_SPEED_BIT] = high_speed_capable;
    status_comb[`BCS_CAP_LIST_BIT] = capability_list_present;
    status_comb[`BCS_INT_PENDING_BIT] = interrupt_pending_flag;
    status_comb[`BCS_RESERVED_LOW_HI_BIT:`BCS_RESERVED_LOW_LO_BIT] = reserved_low;
  end

  assign status_word = status_comb;

  // =====================================================
  // Read port
  // Unaddressed reads return zero so a stale word never leaks out
  reg [15:0] nxt_rdata;

  assign cfg_hit = addr_is_status;

  always @* begin
    nxt_rdata = 16'h0000;
    if (cfg_rd && addr_is_status) begin
      nxt_rdata = status_word;
    end
  end

  // Registered so read data stands for one full cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_rdata <= `BCS_STATUS_RESET;
    end else begin
      cfg_rdata <= nxt_rdata;
    end
  end

endmodule

// *** sim/bcs_status_word_props.sv ***
`timescale 1ns/10ps
module bcs_props(input wire clk, input wire rst_n, input wire cfg_rd, input wire [7:0] cfg_addr,
  input wire [15:0] cmd_word, input wire [15:0] cfg_rdata, input wire [15:0] status_word,
  input wire ev_poisoned_tlp_rx, input wire ev_cpl_abort_rx, input wire cfg_wr,
  input wire [1:0] cfg_be, input wire [15:0] cfg_wdata);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  fixed_bits_a: assert property ((status_word & 16'h06FF) == 16'h0010) else $error("fixed");
  poison_set_a: assert property (ev_poisoned_tlp_rx |=> status_word[15]) else $error("b15");
  abort_set_a: assert property (ev_cpl_abort_rx |=> status_word[12]) else $error("b12");
  serr_gate_a: assert property (!cmd_word[8] && !status_word[14] |=> !status_word[14])
    else $error("b14");
  perr_gate_a: assert property (!cmd_word[6] && !status_word[8] |=> !status_word[8])
    else $error("b8");
  read_back_a: assert property (cfg_rd && cfg_addr == 8'h06 |=> cfg_rdata == $past(status_word))
    else $error("rd");
  read_miss_a: assert property (cfg_rd && cfg_addr != 8'h06 |=> cfg_rdata == 16'h0000)
    else $error("miss");
  flag_hold_a: assert property (status_word[15] &&
    !(cfg_wr && cfg_addr == 8'h06 && cfg_be[1] && cfg_wdata[15]) |=> status_word[15])
    else $error("hold");
  flag_clear_a: assert property (cfg_wr && cfg_addr == 8'h06 && cfg_be[1] &&
    cfg_wdata[12] && !ev_cpl_abort_rx |=> !status_word[12]) else $error("clear");
endmodule
bind bcs_status_word bcs_props bcs_props_inst(.clk, .rst_n, .cfg_rd, .cfg_addr, .cmd_word,
  .cfg_rdata, .status_word, .ev_poisoned_tlp_rx, .ev_cpl_abort_rx, .cfg_wr, .cfg_be, .cfg_wdata);

// *** sim/bcs_host.sv ***
`timescale 1ns/10ps
module bcs_host(input wire clk, output reg cfg_rd, output reg cfg_wr, output reg [7:0] cfg_addr,
  output reg [1:0] cfg_be, output reg [15:0] cfg_wdata);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = 28'h0;
  // Idle address and data lines show inverted values so stale data never matches
  task acc(input w, input [7:0] a, input [1:0] b, input [15:0] d);
    begin
      @(negedge clk) {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {~w, w, a, b, d};
      @(negedge clk) {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {2'h0, ~a, ~d};
    end
  endtask
endmodule

// *** sim/bcs_status_word_tb_top.sv ***
`timescale 1ns/10ps
module bcs_status_word_tb_top;
  reg clk = 1'h0, rst_n = 1'h0;
  reg [6:0] ev = 7'h00;
  reg [15:0] cmd = 16'h0000, x = 16'h0000, wd;
  reg [7:0] a;
  reg [1:0] be;
  integer seed = 32'h0E4697E5, tests_run = 0, fail_count = 0, cyc = 0, i;
  wire cfg_rd, cfg_wr;
  wire [7:0] cfg_addr;
  wire [1:0] cfg_be;
  wire [15:0] cfg_wdata, cfg_rdata, status_word;
  always #2 clk = ~clk;
  bcs_host bcs_host_inst(.clk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata);
  bcs_status_word bcs_status_word_inst(.clk, .rst_n, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_hit(), .ev_poisoned_tlp_rx(ev[0]), .ev_err_msg_tx(ev[1]),
    .ev_cpl_unsupported_rx(ev[2]), .ev_cpl_abort_rx(ev[3]), .ev_cpl_abort_tx(ev[4]),
    .ev_poisoned_cpl_data_rx(ev[5]), .ev_write_poisoned(ev[6]), .cmd_word(cmd),
    .poison_report_enable(), .system_error_report_enable(), .status_word);
  function [15:0] setm(input [6:0] e, input [15:0] c);
    setm = {e[0], e[1] & c[8], e[2], e[3], e[4], 2'h0, (e[5] | e[6]) & c[6], 8'h00};
  endfunction
  task chk(input [47:0] nm, input [15:0] e, input [15:0] s);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("FAIL %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task conclude;
    begin
      $display("tests_run %0d fail_count %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    chk("status", 16'h0010, status_word);
    rst_n = 1'h1;
    for (i = 0; i < 150; i = i + 1) begin
      wd = (i < 4) ? 16'hFFFF : $random(seed);
      a = ($random(seed) & 1) ? 8'h06 : 8'h04;
      cmd = $random(seed);
      be = (i < 4) ? 2'h3 : $random(seed);
      fork
        bcs_host_inst.acc(1'h1, a, be, wd);
        begin
          @(negedge clk) ev = (i < 4) ? 7'h00 : $random(seed) & $random(seed) & $random(seed);
          x = (x & ~((a == 8'h06) ? wd & {{8{be[1]}}, {8{be[0]}}} & 16'hF900 : 16'h0000))
            | setm(ev, cmd);
          @(negedge clk) ev = 7'h00;
        end
      join
      bcs_host_inst.acc(1'h0, a, 2'h3, 16'h0000);
      chk("rdata", (a == 8'h06) ? x | 16'h0010 : 16'h0000, cfg_rdata);
      chk("status", x | 16'h0010, status_word);
    end
    conclude;
  end
endmodule
